// ---- core/ddrbs_pkg.sv ----
package ddrbs_pkg;

	// ------------------------------------------------
	// timing
	// ------------------------------------------------
	localparam int unsigned SYS_PERIOD_NS = 20;   // i_clk period
	localparam int unsigned CK_PERIOD_NS  = 160;  // memory clock period
	localparam int unsigned CK_HALF_CYC   = CK_PERIOD_NS / (2 * SYS_PERIOD_NS);
	localparam logic [7:0]  CMD_R0_Q      = 8'h02; // quarter of command rise
	localparam logic [7:0]  CMD_HOLD_Q    = 8'h04; // quarter command ends
	localparam logic [7:0]  READ_SLACK_Q  = 8'h04; // sync delay margin

	// ------------------------------------------------
	// register offsets
	// ------------------------------------------------
	localparam logic [7:0] OFS_CFG  = 8'h00;
	localparam logic [7:0] OFS_CMD  = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_WBUF = 8'h20; // eight words, by column
	localparam logic [7:0] OFS_RBUF = 8'h40; // eight words, by column

	// ------------------------------------------------
	// field positions
	// ------------------------------------------------
	localparam int unsigned CFG_BL8_BIT    = 0;
	localparam int unsigned CFG_ILV_BIT    = 1;
	localparam int unsigned CFG_CL_LSB     = 4;
	localparam int unsigned CFG_AL_LSB     = 8;
	localparam int unsigned CFG_WR_LSB     = 12;
	localparam int unsigned CMD_WR_BIT     = 0;
	localparam int unsigned CMD_AP_BIT     = 1;
	localparam int unsigned CMD_BA_LSB     = 2;
	localparam int unsigned CMD_COL_LSB    = 4;
	localparam int unsigned COL_W          = 9;
	localparam int unsigned ADDR_AP_BIT    = 10;
	localparam int unsigned STAT_BUSY_BIT  = 0;
	localparam int unsigned STAT_DONE_BIT  = 1;
	localparam int unsigned STAT_BEAT_LSB  = 4;
	localparam int unsigned WBUF_DM_LSB    = 16;

	// ------------------------------------------------
	// reset values
	// ------------------------------------------------
	localparam logic [31:0] CFG_RST = 32'h0000_2030; // bl4, seq, cl3, al0, wr2

	// ------------------------------------------------
	// engine states
	// ------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRITE,
		ST_READ
	} ddrbs_state_t;

endpackage

// ---- core/ddrbs_ord_if.sv ----
// ------------------------------------------------
// burst column order request
// ------------------------------------------------
interface ddrbs_ord_if;
	logic [2:0] start; // start column, low three bits
	logic       bl8;   // burst of eight
	logic       ilv;   // interleaved order
	logic [2:0] beat;  // beat index
	logic [2:0] col;   // column of that beat

	modport req (output start, output bl8, output ilv, output beat, input col);
	modport calc (input start, input bl8, input ilv, input beat, output col);
endinterface

// ---- core/ddrbs_col_order.sv ----
// ------------------------------------------------
// column of a beat within its aligned group
// ------------------------------------------------
module ddrbs_col_order (
	// order request
	ddrbs_ord_if.calc o
);

	// the group never changes, so only low bits move
	always_comb begin
		if (o.ilv) begin
			// interleaved: start xor beat, A2 kept for bl4
			o.col = o.start ^ o.beat;
		end else begin
			// sequential: nibble rotation, A2 flips halfway in bl8
			o.col[1:0] = o.start[1:0] + o.beat[1:0];
			o.col[2]   = o.start[2] ^ (o.bl8 & o.beat[2]);
		end
	end

endmodule

// ---- core/ddrbs_host.sv ----
// What the document requires of this block
// - never interrupt a burst of four
// - no burst terminate; never stop early
// - write latency is AL plus CL minus one
// - write preamble half clock, beats on edges
// - one mask per byte, write timing only
// - bl8 read interrupted only by read
// - bl8 write interrupted only by write
// - interrupt exactly two clocks after command
// - auto-precharge bursts are never interrupted
// - later timing uses programmed burst length
// - column commands at least two clocks apart
//
// The placing of the registers and the strobed register port were decided locally.
module ddrbs_host #(
	parameter int unsigned CK_HALF = ddrbs_pkg::CK_HALF_CYC, // even, >= 2
	parameter int unsigned ADDR_W  = 13,
	parameter int unsigned DQ_W    = 16
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_sys_rst,
	// software port
	input  wire logic [7:0]            i_addr,
	input  wire logic [31:0]           i_wdata,
	input  wire logic                  i_wr,
	input  wire logic                  i_rd,
	output logic      [31:0]           o_rdata,
	// memory clock and command
	output logic                       o_ck,
	output logic                       o_ck_n,
	output logic                       o_cs_n,
	output logic                       o_ras_n,
	output logic                       o_cas_n,
	output logic                       o_we_n,
	output logic      [1:0]            o_ba,
	output logic      [ADDR_W-1:0]     o_a,
	// data, strobe and mask
	input  wire logic [DQ_W-1:0]       i_dq,
	output logic      [DQ_W-1:0]       o_dq,
	output logic                       o_dq_oe,
	output logic      [DQ_W/8-1:0]     o_dm,
	input  wire logic                  i_dqs,
	output logic                       o_dqs,
	output logic                       o_dqs_oe
);

	// ------------------------------------------------
	// local sizes
	// ------------------------------------------------
	localparam int unsigned MW  = DQ_W / 8;          // mask lanes
	localparam int unsigned QTR = CK_HALF / 2;       // sys cycles a quarter
	localparam logic [7:0]  QTR_LAST = 8'(QTR - 1);

	// ------------------------------------------------
	// state
	// ------------------------------------------------
	typedef struct packed {
		logic [7:0]                  div;    // quarter divider
		logic [1:0]                  qp;     // quarter of memory clock
		logic                        ck;     // memory clock level
		ddrbs_pkg::ddrbs_state_t     st;     // engine state
		logic [7:0]                  t;      // quarters since command
		logic [31:0]                 cfg;    // latency and burst setup
		logic [31:0]                 cmd;    // accepted command word
		logic                        pend;   // command waiting to go
		logic                        done;   // sticky completion
		logic [3:0]                  wbeat;  // next write beat
		logic [3:0]                  rbeat;  // read beats caught
		logic [7:0][DQ_W+MW-1:0]     wbuf;   // write data and mask
		logic [7:0][DQ_W-1:0]        rbuf;   // read data by column
		logic                        cs_n;
		logic                        ras_n;
		logic                        cas_n;
		logic                        we_n;
		logic [1:0]                  ba;
		logic [ADDR_W-1:0]           a;
		logic [DQ_W-1:0]             dq;
		logic                        dq_oe;
		logic [MW-1:0]               dm;
		logic                        dqs;
		logic                        dqs_oe;
		logic [2:0]                  dqs_s;  // strobe synchroniser
		logic                        dqs_f;  // settled strobe level
		logic [DQ_W-1:0]             dq_s0;  // data synchroniser
		logic [DQ_W-1:0]             dq_s1;
		logic [DQ_W-1:0]             dq_s2;
		logic [31:0]                 rdata;  // read answer
	} ddrbs_st_t;

	ddrbs_st_t q;  // registered state
	ddrbs_st_t d;  // next state

	// ------------------------------------------------
	// latency helpers, all in quarter clocks
	// ------------------------------------------------
	// read latency is al plus cl
	function automatic logic [7:0] rl_q(input logic [31:0] c);
		logic [7:0] al;
		logic [7:0] cl;
		al = {3'h0, c[ddrbs_pkg::CFG_AL_LSB +: 3], 2'h0};
		cl = {3'h0, c[ddrbs_pkg::CFG_CL_LSB +: 3], 2'h0};
		return al + cl;
	endfunction

	// write latency one clock less
	function automatic logic [7:0] wl_q(input logic [31:0] c);
		return rl_q(c) - 8'h04;
	endfunction

	// beats span two quarters each; equals bl/2 clocks
	function automatic logic [7:0] span_q(input logic [31:0] c);
		return c[ddrbs_pkg::CFG_BL8_BIT] ? 8'h10 : 8'h08;
	endfunction

	// ------------------------------------------------
	// column order unit
	// ------------------------------------------------
	ddrbs_ord_if ord ();

	assign ord.start = q.cmd[ddrbs_pkg::CMD_COL_LSB +: 3];
	assign ord.bl8   = q.cfg[ddrbs_pkg::CFG_BL8_BIT];
	assign ord.ilv   = q.cfg[ddrbs_pkg::CFG_ILV_BIT];
	// only one direction runs at a time, so one unit serves both
	assign ord.beat  = (q.st == ddrbs_pkg::ST_WRITE) ? q.wbeat[2:0] : q.rbeat[2:0];

	ddrbs_col_order u_order (
		.o (ord)
	);

	// ------------------------------------------------
	// next state
	// ------------------------------------------------
	always_comb begin
		logic       tick;   // quarter boundary
		logic       stable; // strobe stages agree
		logic       sedge;  // settled strobe change
		logic [7:0] n;      // next quarter count
		logic [7:0] o;      // quarters past write latency
		logic [7:0] fin;    // quarter the command ends
		logic       wr;     // command is a write
		logic [7:0] sp;     // programmed burst span, quarters
		tick   = (q.div == QTR_LAST);
		stable = (q.dqs_s[1] == q.dqs_s[2]);
		sedge  = stable && (q.dqs_s[2] != q.dqs_f);
		n      = q.t + 8'h01;
		o      = n - wl_q(q.cfg);
		wr     = q.cmd[ddrbs_pkg::CMD_WR_BIT];
		sp     = span_q(q.cfg);
		fin    = '0;
		d      = q;

		// memory clock divider; high for quarters 0 and 1
		d.div = tick ? 8'h00 : q.div + 8'h01;
		if (tick) begin
			d.qp = q.qp + 2'h1;
			d.ck = ~d.qp[1];
		end

		// pin synchronisers, three stages each
		d.dqs_s = {q.dqs_s[1:0], i_dqs};
		d.dq_s0 = i_dq;
		d.dq_s1 = q.dq_s0;
		d.dq_s2 = q.dq_s1;
		if (stable) begin
			d.dqs_f = q.dqs_s[2];
		end

		// software writes
		if (i_wr) begin
			if (i_addr == ddrbs_pkg::OFS_CFG) begin
				// frozen while a burst runs so timing matches the burst
				if (q.st == ddrbs_pkg::ST_IDLE) begin
					d.cfg = i_wdata;
				end
			end else if (i_addr == ddrbs_pkg::OFS_CMD) begin
				// one command at a time: no burst is ever cut short
				if (q.st == ddrbs_pkg::ST_IDLE && !q.pend) begin
					d.cmd  = i_wdata;
					d.pend = 1'b1;
					d.done = 1'b0;
				end
			end else if (i_addr == ddrbs_pkg::OFS_STAT) begin
				// write one to clear done
				if (i_wdata[ddrbs_pkg::STAT_DONE_BIT]) begin
					d.done = 1'b0;
				end
			end else if (i_addr[7:5] == ddrbs_pkg::OFS_WBUF[7:5]) begin
				d.wbuf[i_addr[4:2]] = i_wdata[DQ_W+MW-1:0];
			end
		end

		// software reads, answered next cycle
		d.rdata = '0;
		if (i_rd) begin
			if (i_addr == ddrbs_pkg::OFS_CFG) begin
				d.rdata = q.cfg;
			end else if (i_addr == ddrbs_pkg::OFS_CMD) begin
				d.rdata = q.cmd;
			end else if (i_addr == ddrbs_pkg::OFS_STAT) begin
				d.rdata[ddrbs_pkg::STAT_BUSY_BIT] = (q.st != ddrbs_pkg::ST_IDLE) | q.pend;
				d.rdata[ddrbs_pkg::STAT_DONE_BIT] = q.done;
				d.rdata[ddrbs_pkg::STAT_BEAT_LSB +: 4] = q.rbeat;
			end else if (i_addr[7:5] == ddrbs_pkg::OFS_WBUF[7:5]) begin
				d.rdata[DQ_W+MW-1:0] = q.wbuf[i_addr[4:2]];
			end else if (i_addr[7:5] == ddrbs_pkg::OFS_RBUF[7:5]) begin
				d.rdata[DQ_W-1:0] = q.rbuf[i_addr[4:2]];
			end
		end

		// burst engine
		case (q.st)
			ddrbs_pkg::ST_IDLE: begin
				// launch on a falling edge so the rise samples it
				if (tick && q.qp == 2'h1 && q.pend) begin
					d.pend  = 1'b0;
					d.t     = '0;
					d.wbeat = '0;
					d.rbeat = '0;
					d.cs_n  = 1'b0;
					d.ras_n = 1'b1;
					d.cas_n = 1'b0;
					d.we_n  = ~wr;
					d.ba    = q.cmd[ddrbs_pkg::CMD_BA_LSB +: 2];
					d.a     = '0;
					d.a[ddrbs_pkg::COL_W-1:0] = q.cmd[ddrbs_pkg::CMD_COL_LSB +: ddrbs_pkg::COL_W];
					// only reads and writes leave here; no stop command
					d.a[ddrbs_pkg::ADDR_AP_BIT] = q.cmd[ddrbs_pkg::CMD_AP_BIT];
					d.st    = wr ? ddrbs_pkg::ST_WRITE : ddrbs_pkg::ST_READ;
				end
			end

			ddrbs_pkg::ST_WRITE: begin
				// recovery counted from the full programmed burst
				fin = ddrbs_pkg::CMD_R0_Q + wl_q(q.cfg) + span_q(q.cfg)
				      + {3'h0, q.cfg[ddrbs_pkg::CFG_WR_LSB +: 3], 2'h0};
				if (tick) begin
					d.t = n;
					if (n == ddrbs_pkg::CMD_HOLD_Q) begin
						d.cs_n = 1'b1;
					end
					if (n >= wl_q(q.cfg)) begin
						if (o == 8'h00) begin
							// preamble: low half a clock before latency
							d.dqs_oe = 1'b1;
							d.dqs    = 1'b0;
							d.dq_oe  = 1'b1;
						end else if (o[0] && o < span_q(q.cfg)) begin
							// beat a quarter ahead of its strobe edge
							d.dq    = q.wbuf[ord.col][DQ_W-1:0];
							d.dm    = q.wbuf[ord.col][ddrbs_pkg::WBUF_DM_LSB +: MW];
							d.wbeat = q.wbeat + 4'h1;
						end else if (!o[0] && o <= span_q(q.cfg)) begin
							d.dqs = ~q.dqs;
						end else if (o == span_q(q.cfg) + 8'h02) begin
							// postamble over; bus given back
							d.dqs_oe = 1'b0;
							d.dq_oe  = 1'b0;
							d.dm     = '0;
						end
					end
					if (n == fin) begin
						d.st     = ddrbs_pkg::ST_IDLE;
						d.done   = 1'b1;
						d.dqs_oe = 1'b0;
						d.dq_oe  = 1'b0;
						d.dm     = '0;
					end
				end
			end

			ddrbs_pkg::ST_READ: begin
				// device owns the bus; mask not driven
				d.dq_oe  = 1'b0;
				d.dqs_oe = 1'b0;
				fin = ddrbs_pkg::CMD_R0_Q + rl_q(q.cfg) + span_q(q.cfg)
				      + ddrbs_pkg::READ_SLACK_Q;
				// window opens half a clock before the first data rise; even beats on rises
				if (sedge && q.t >= rl_q(q.cfg)
				    && q.rbeat < sp[4:1]
				    && q.dqs_s[2] == ~q.rbeat[0]) begin
					d.rbuf[ord.col] = q.dq_s2;
					d.rbeat = q.rbeat + 4'h1;
				end
				if (tick) begin
					d.t = n;
					if (n == ddrbs_pkg::CMD_HOLD_Q) begin
						d.cs_n = 1'b1;
					end
					if (n == fin) begin
						d.st   = ddrbs_pkg::ST_IDLE;
						d.done = 1'b1;
					end
				end
			end

			default: begin
				d.st = ddrbs_pkg::ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------
	// state register
	// ------------------------------------------------
	// synchronous reset; pins come up deselected and released
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q       <= '0;
			q.cfg   <= ddrbs_pkg::CFG_RST;
			q.ck    <= 1'b1;
			q.cs_n  <= 1'b1;
			q.ras_n <= 1'b1;
			q.cas_n <= 1'b1;
			q.we_n  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------
	// outputs straight from flops, o_ck_n as the inverse of ck
	// ------------------------------------------------
	assign o_rdata  = q.rdata;
	assign o_ck     = q.ck;
	assign o_ck_n   = ~q.ck;
	assign o_cs_n   = q.cs_n;
	assign o_ras_n  = q.ras_n;
	assign o_cas_n  = q.cas_n;
	assign o_we_n   = q.we_n;
	assign o_ba     = q.ba;
	assign o_a      = q.a;
	assign o_dq     = q.dq;
	assign o_dq_oe  = q.dq_oe;
	assign o_dm     = q.dm;
	assign o_dqs    = q.dqs;
	assign o_dqs_oe = q.dqs_oe;

endmodule

// ---- verification/ddrbs_host_assertions.sv ----
module ddrbs_host_assertions #(
	parameter int unsigned DQ_W = 16
) (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	// software port
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	// memory link
	input  wire logic              o_ck,
	input  wire logic              o_ck_n,
	input  wire logic              o_cs_n,
	input  wire logic              o_ras_n,
	input  wire logic              o_cas_n,
	input  wire logic              o_we_n,
	input  wire logic              o_dq_oe,
	input  wire logic [DQ_W/8-1:0] o_dm,
	input  wire logic              o_dqs,
	input  wire logic              o_dqs_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// ------------------------------------------------
	// helper state
	// ------------------------------------------------
	logic [31:0] cfg_q;  // mirror of the config word
	logic [7:0]  wcnt_q; // sys cycles since last command
	logic [3:0]  ecnt_q; // strobe edges in this write
	logic [7:0]  wl;     // write latency in ck

	assign wl = 8'(cfg_q[10:8]) + 8'(cfg_q[6:4]) - 8'h01;

	// config is only written while idle, so no busy check here
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cfg_q <= ddrbs_pkg::CFG_RST;
			wcnt_q <= 8'h00;
			ecnt_q <= 4'h0;
		end else begin
			if (i_wr && i_addr == ddrbs_pkg::OFS_CFG) cfg_q <= i_wdata;
			wcnt_q <= $fell(o_cs_n) ? 8'h01 : wcnt_q + 8'h01;
			ecnt_q <= $rose(o_dqs_oe) ? 4'h0 : ecnt_q + 4'($changed(o_dqs) && o_dqs_oe);
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	chk_cmd_kind: assert property (!o_cs_n |-> o_ras_n && !o_cas_n)
		else $error("command other than read or write");
	chk_dm_idle: assert property (!o_dq_oe |-> o_dm == '0)
		else $error("mask driven outside a write");
	chk_wr_pre: assert property ($rose(o_dqs_oe) |-> !o_dqs [*4] ##1 o_dqs)
		else $error("write preamble wrong");
	chk_oe_pair: assert property (o_dq_oe == o_dqs_oe)
		else $error("data and strobe enables differ");
	chk_cmd_gap: assert property ($fell(o_cs_n) |-> !o_cs_n [*8] ##1 o_cs_n [*8])
		else $error("command spacing wrong");
	chk_wr_lat: assert property ($rose(o_dqs_oe) |-> wcnt_q == 8'(8 * wl))
		else $error("write latency wrong");
	chk_beat_cnt: assert property ($fell(o_dqs_oe) |-> ecnt_q == (cfg_q[0] ? 4'h8 : 4'h4))
		else $error("strobe edge count wrong");
	chk_ck_shape: assert property ($rose(o_ck) |-> o_ck [*4] ##1 !o_ck [*4] ##1 o_ck)
		else $error("memory clock shape wrong");
	chk_ck_pair: assert property (o_ck_n == !o_ck)
		else $error("memory clock pair not complementary");
endmodule

bind ddrbs_host ddrbs_host_assertions #(.DQ_W(DQ_W)) u_chk (.i_clk, .i_sys_rst, .i_addr, .i_wdata,
	.i_wr, .o_ck, .o_ck_n, .o_cs_n, .o_ras_n, .o_cas_n, .o_we_n, .o_dq_oe, .o_dm, .o_dqs, .o_dqs_oe);

// ---- verification/ddrbs_mem_model.sv ----
module ddrbs_mem_model (
	// mode, set by the bench
	input  wire logic        i_bl8,
	input  wire logic        i_ilv,
	input  wire logic [2:0]  i_cl,
	input  wire logic [2:0]  i_al,
	// command pins
	input  wire logic        i_ck,
	input  wire logic        i_cs_n,
	input  wire logic        i_ras_n,
	input  wire logic        i_cas_n,
	input  wire logic        i_we_n,
	input  wire logic [1:0]  i_ba,
	input  wire logic [12:0] i_a,
	// host drive
	input  wire logic [15:0] i_dq,
	input  wire logic        i_dq_oe,
	input  wire logic [1:0]  i_dm,
	input  wire logic        i_dqs,
	input  wire logic        i_dqs_oe,
	// resolved lines
	output logic      [15:0] o_dq,
	output logic             o_dqs
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [int]; // array, unwritten words read a pattern
	logic [15:0] m_dq;      // device data
	logic        m_dqs;     // device strobe
	logic        m_oe;      // device drives

	// released lines wander with ck, never hold a value
	assign o_dq = i_dq_oe ? i_dq : m_oe ? m_dq : {16{i_ck}} ^ 16'h5A5A;
	assign o_dqs = i_dqs_oe ? i_dqs : m_oe ? m_dqs : ~i_ck;

	function automatic logic [15:0] rd_word(int k);
		return mem.exists(k) ? mem[k] : 16'hA5A5 ^ k[15:0];
	endfunction

	// beats below four never touch A2
	function automatic logic [2:0] col_of(logic [2:0] s, logic [2:0] i);
		return i_ilv ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]};
	endfunction

	task automatic rd_burst(int base, logic [2:0] s);
		repeat (int'(i_al) + int'(i_cl) - 1) @(posedge i_ck);
		m_oe = 1'b1;
		m_dqs = 1'b0;
		@(posedge i_ck);
		for (int k = 0; k < (i_bl8 ? 8 : 4); k++) begin
			m_dq = rd_word(base + int'(col_of(s, k[2:0])));
			m_dqs = !k[0];
			if (k[0]) @(posedge i_ck); else @(negedge i_ck);
		end
		m_oe = 1'b0;
	endtask

	// stops after the programmed beats, later edges are left alone
	task automatic wr_burst(int base, logic [2:0] s);
		logic [15:0] w;
		int          key;
		for (int k = 0; k < (i_bl8 ? 8 : 4); k++) begin
			if (k[0]) @(negedge i_dqs); else @(posedge i_dqs);
			key = base + int'(col_of(s, k[2:0]));
			w = rd_word(key);
			if (!i_dm[0]) w[7:0] = i_dq[7:0];
			if (!i_dm[1]) w[15:8] = i_dq[15:8];
			mem[key] = w;
		end
	endtask

	initial begin
		m_oe = 1'b0;
		m_dq = 16'h0000;
		m_dqs = 1'b0;
	end

	// command decode: only column commands, any bank
	always @(posedge i_ck) begin
		if (!i_cs_n && i_ras_n && !i_cas_n) begin
			if (i_we_n) rd_burst(int'(i_ba) * 512 + int'({i_a[8:3], 3'h0}), i_a[2:0]);
			else wr_burst(int'(i_ba) * 512 + int'({i_a[8:3], 3'h0}), i_a[2:0]);
		end
	end
endmodule

// ---- verification/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, wr, rd, ck, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_h, dqs_oe, dqs_w;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, s;
	logic [1:0]  ba, dm, b;
	logic [12:0] a;
	logic [15:0] dq_h, dq_w;
	logic [8:0]  c;
	logic        bl8, ilv;
	logic [2:0]  cl, al;
	logic [17:0] wb [8];
	logic [15:0] exp_mem [int];
	int          n_mismatch, checks_done;

	ddrbs_host u_ddrbs_host (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .o_ck(ck), .o_ck_n(), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
		.o_we_n(we_n), .o_ba(ba), .o_a(a), .i_dq(dq_w), .o_dq(dq_h), .o_dq_oe(dq_oe), .o_dm(dm),
		.i_dqs(dqs_w), .o_dqs(dqs_h), .o_dqs_oe(dqs_oe));
	ddrbs_mem_model u_ddrbs_mem_model (.i_bl8(bl8), .i_ilv(ilv), .i_cl(cl), .i_al(al), .i_ck(ck),
		.i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_a(a), .i_dq(dq_h),
		.i_dq_oe(dq_oe), .i_dm(dm), .i_dqs(dqs_h), .i_dqs_oe(dqs_oe), .o_dq(dq_w), .o_dqs(dqs_w));

	// ------------------------------------------------
	// clock and closing
	// ------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic close_out();
		if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// a hang is far beyond the few thousand cycles expected
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		close_out();
	end

	// ------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------
	task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic bw(logic [7:0] ad, logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic br(logic [7:0] ad, output logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	function automatic logic [15:0] ev(int k);
		return exp_mem.exists(k) ? exp_mem[k] : 16'hA5A5 ^ k[15:0];
	endfunction

	// one burst; memory is checked by column, so order faults show
	task automatic burst(logic w, logic [1:0] bk, logic [8:0] col);
		logic [15:0] e;
		int          base, n, k;
		n = bl8 ? 8 : 4;
		base = int'(bk) * 512 + int'(col & (bl8 ? 9'h1F8 : 9'h1FC));
		bw(ddrbs_pkg::OFS_CMD, {19'h0, col, bk, 1'($urandom), w});
		s = 32'h0;
		for (int i = 0; i < 300 && !s[1]; i++) br(ddrbs_pkg::OFS_STAT, s);
		cmp("stat", w ? 32'h2 : 32'(n * 16 + 2), s & (w ? 32'h3 : 32'hF3));
		for (int j = 0; j < n; j++) begin
			k = base + j;
			if (w) begin
				e = ev(k);
				if (!wb[k & 7][16]) e[7:0] = wb[k & 7][7:0];
				if (!wb[k & 7][17]) e[15:8] = wb[k & 7][15:8];
				exp_mem[k] = e;
				cmp("mem", 32'(e), 32'(u_ddrbs_mem_model.mem[k]));
			end else begin
				br(ddrbs_pkg::OFS_RBUF + 8'(4 * (k & 7)), s);
				cmp("rbuf", 32'(ev(k)), s);
			end
		end
	endtask

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		{wr, rd, addr, wdata} = '0;
		n_mismatch = 0;
		checks_done = 0;
		bl8 = 1'b0;
		ilv = 1'b0;
		cl = 3'h3;
		al = 3'h0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		void'($urandom(22));
		br(ddrbs_pkg::OFS_CFG, s);
		cmp("cfg reset", ddrbs_pkg::CFG_RST, s);
		br(8'hFC, s);
		cmp("unmapped", 32'h0, s);
		// every length and order, random latencies and places
		for (int i = 0; i < 16; i++) begin
			bl8 = i[0];
			ilv = i[1];
			cl = 3'(3 + $urandom % 3);
			al = 3'($urandom % 3);
			bw(ddrbs_pkg::OFS_CFG, {17'h0, 3'h2, 1'b0, al, 1'b0, cl, 2'h0, ilv, bl8});
			for (int j = 0; j < 8; j++) begin
				wb[j] = 18'($urandom);
				bw(ddrbs_pkg::OFS_WBUF + 8'(4 * j), {14'h0, wb[j]});
			end
			b = 2'($urandom);
			c = 9'($urandom);
			burst(1'b1, b, c);
			burst(1'b0, b, c);
			burst(1'b0, ~b, 9'($urandom));
		end
		close_out();
	end
endmodule
